// ===== hdl/ido_latch_bank.sv
// Isolated output latch bank: bus target with config header and 48 output latches.
// Assumes bus pins are synchronous to mclk; the board resolves the three-state wires.
//
// Contract
// - Decode offset from low three address bits
// - Occupy eight byte-wide I/O locations
// - Fixed offset map, offsets 3 and 7 unused
// - Byte write latches and drives outputs
// - Byte read returns latched output state
// - Sixteen outputs per group, high byte +8; the code puts it 1, 2 and 1 bytes above the low byte
// - Identification codes in configuration space
// - Base and interrupt only from enumeration
// - Reset clears every output latch
module ido_latch_bank
    import ido_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE = 16'h1a2b, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h3c4d  // Arbitrary value
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic frameN,
    input wire logic irdyN,
    input wire logic idsel,
    input wire logic [3:0] cbeN,
    input wire logic [31:0] adIn,
    output logic [31:0] adOut,
    output logic adOe,
    output logic parOut,
    output logic parOe,
    output logic devselN,
    output logic trdyN,
    output logic stopN,
    output logic ctlOe,
    output logic [15:0] group0Out,
    output logic [15:0] group1Out,
    output logic [15:0] group2Out
);
    ido_state_e state_reg, state_next;
    ido_req_s req_reg, req_next;
    logic [7:0] latch_reg [WINDOW_BYTES];
    logic [7:0] latch_next [WINDOW_BYTES];
    logic ioEn_reg, ioEn_next;
    logic [28:0] bar_reg, bar_next;
    logic [7:0] intLine_reg, intLine_next;
    logic prevFrameN_reg;
    logic [31:0] adOut_reg, adOut_next;
    logic adOe_reg, adOe_next;
    logic parOut_reg, parOut_next;
    logic parOe_reg, parOe_next;
    logic devselN_reg, devselN_next;
    logic trdyN_reg, trdyN_next;
    logic stopN_reg, stopN_next;
    logic ctlOe_reg, ctlOe_next;

    logic start;
    logic hit;
    logic isRead;
    logic isCfg;
    logic [31:0] readWord;
    logic [5:0] cfgIdx;
    logic [2:0] byteOfs;

    // Address phase seen as the first cycle with frame low
    assign start = !frameN && prevFrameN_reg;

    always_comb begin
        hit = 1'b0;
        unique case (cbeN)
            CMD_IO_RD, CMD_IO_WR:
                hit = ioEn_reg && (adIn[31:OFS_BITS] == bar_reg);
            CMD_CFG_RD, CMD_CFG_WR:
                hit = idsel && (adIn[1:0] == 2'b00) && (adIn[10:8] == 3'b000);
            default:
                hit = 1'b0;
        endcase
    end

    assign isRead = (req_reg.cmd == CMD_IO_RD) || (req_reg.cmd == CMD_CFG_RD);
    assign isCfg = (req_reg.cmd == CMD_CFG_RD) || (req_reg.cmd == CMD_CFG_WR);
    assign cfgIdx = req_reg.addr[7:2];

    // Dword holding four byte lanes; unused slots never load, so they read zero
    always_comb begin
        readWord = 32'h0;
        if (isCfg) begin
            unique case (cfgIdx)
                CFG_IDX_ID: readWord = {DEVICE_CODE, VENDOR_CODE};
                CFG_IDX_CMD: readWord = {31'h0, ioEn_reg};
                CFG_IDX_BAR0: readWord = {bar_reg, BAR_LOW_BITS};
                CFG_IDX_INTR: readWord = {16'h0, INT_PIN_NONE, intLine_reg};
                default: readWord = 32'h0;
            endcase
        end else begin
            for (int i = 0; i < 4; i++) begin
                readWord[8*i +: 8] = latch_reg[{req_reg.addr[2], i[1:0]}];
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        latch_next = latch_reg;
        ioEn_next = ioEn_reg;
        bar_next = bar_reg;
        intLine_next = intLine_reg;
        adOut_next = adOut_reg;
        adOe_next = adOe_reg;
        devselN_next = devselN_reg;
        trdyN_next = trdyN_reg;
        stopN_next = stopN_reg;
        ctlOe_next = ctlOe_reg;
        byteOfs = 3'h0;
        unique case (state_reg)
            ST_IDLE: begin
                if (start && hit) begin
                    req_next.cmd = cbeN;
                    req_next.addr = adIn;
                    devselN_next = 1'b0;
                    ctlOe_next = 1'b1;
                    state_next = ST_CLAIM;
                end
            end
            ST_CLAIM: begin
                // Single data phase only: stop with the data ends any burst
                trdyN_next = 1'b0;
                stopN_next = 1'b0;
                adOe_next = isRead;
                adOut_next = readWord;
                state_next = ST_XFER;
            end
            ST_XFER: begin
                if (!irdyN) begin
                    if (req_reg.cmd == CMD_IO_WR) begin
                        for (int i = 0; i < 4; i++) begin
                            byteOfs = {req_reg.addr[2], i[1:0]};
                            if (!cbeN[i] && byteOfs != OFS_UNUSED_A && byteOfs != OFS_UNUSED_B) begin
                                latch_next[byteOfs] = adIn[8*i +: 8];
                            end
                        end
                    end else if (req_reg.cmd == CMD_CFG_WR) begin
                        if (cfgIdx == CFG_IDX_CMD && !cbeN[0]) begin
                            ioEn_next = adIn[CMD_IO_EN_BIT];
                        end
                        if (cfgIdx == CFG_IDX_BAR0) begin
                            for (int i = 0; i < 4; i++) begin
                                if (!cbeN[i]) begin
                                    if (i == 0) begin
                                        bar_next[4:0] = adIn[7:3];
                                    end else begin
                                        bar_next[8*i-3 +: 8] = adIn[8*i +: 8];
                                    end
                                end
                            end
                        end
                        if (cfgIdx == CFG_IDX_INTR && !cbeN[0]) begin
                            intLine_next = adIn[7:0];
                        end
                    end
                    devselN_next = 1'b1;
                    trdyN_next = 1'b1;
                    stopN_next = 1'b1;
                    adOe_next = 1'b0;
                    state_next = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // Control lines driven high one cycle before letting go
                ctlOe_next = 1'b0;
                state_next = ST_IDLE;
            end
        endcase
    end

    // Parity trails the data it covers by one clock
    always_comb begin
        parOut_next = (^adOut_reg) ^ (^cbeN);
        parOe_next = adOe_reg;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            req_reg <= '0;
            for (int i = 0; i < WINDOW_BYTES; i++) begin
                latch_reg[i] <= LATCH_RST;
            end
            ioEn_reg <= 1'b0;
            bar_reg <= BAR_RST;
            intLine_reg <= INT_LINE_RST;
            prevFrameN_reg <= 1'b1;
            adOut_reg <= 32'h0;
            adOe_reg <= 1'b0;
            parOut_reg <= 1'b0;
            parOe_reg <= 1'b0;
            devselN_reg <= 1'b1;
            trdyN_reg <= 1'b1;
            stopN_reg <= 1'b1;
            ctlOe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            latch_reg <= latch_next;
            ioEn_reg <= ioEn_next;
            bar_reg <= bar_next;
            intLine_reg <= intLine_next;
            prevFrameN_reg <= frameN;
            adOut_reg <= adOut_next;
            adOe_reg <= adOe_next;
            parOut_reg <= parOut_next;
            parOe_reg <= parOe_next;
            devselN_reg <= devselN_next;
            trdyN_reg <= trdyN_next;
            stopN_reg <= stopN_next;
            ctlOe_reg <= ctlOe_next;
        end
    end

    assign adOut = adOut_reg;
    assign adOe = adOe_reg;
    assign parOut = parOut_reg;
    assign parOe = parOe_reg;
    assign devselN = devselN_reg;
    assign trdyN = trdyN_reg;
    assign stopN = stopN_reg;
    assign ctlOe = ctlOe_reg;
    assign group0Out = {latch_reg[OFS_G0_HI], latch_reg[OFS_G0_LO]};
    assign group1Out = {latch_reg[OFS_G1_HI], latch_reg[OFS_G1_LO]};
    assign group2Out = {latch_reg[OFS_G2_HI], latch_reg[OFS_G2_LO]};
endmodule

// ===== hdl/ido_pkg.sv
// Constants, types and register map of the isolated output latch bank.
// Assumes a 32-bit bus that runs on the same clock as the block.
package ido_pkg;
    // Byte offsets of the output latches inside the eight-byte window
    localparam logic [2:0] OFS_G0_LO = 3'h0;
    localparam logic [2:0] OFS_G0_HI = 3'h1;
    localparam logic [2:0] OFS_G1_LO = 3'h2;
    localparam logic [2:0] OFS_UNUSED_A = 3'h3;
    localparam logic [2:0] OFS_G1_HI = 3'h4;
    localparam logic [2:0] OFS_G2_LO = 3'h5;
    localparam logic [2:0] OFS_G2_HI = 3'h6;
    localparam logic [2:0] OFS_UNUSED_B = 3'h7;
    localparam int WINDOW_BYTES = 8;
    localparam int OFS_BITS = 3;
    localparam logic [7:0] LATCH_RST = 8'h00;

    // Bus commands
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_CFG_WR = 4'hb;

    // Configuration dword indices
    localparam logic [5:0] CFG_IDX_ID = 6'h00;
    localparam logic [5:0] CFG_IDX_CMD = 6'h01;
    localparam logic [5:0] CFG_IDX_BAR0 = 6'h04;
    localparam logic [5:0] CFG_IDX_INTR = 6'h0f;
    localparam int CMD_IO_EN_BIT = 0;
    localparam logic [28:0] BAR_RST = 29'h0;
    localparam logic [7:0] INT_LINE_RST = 8'h00;
    localparam logic [7:0] INT_PIN_NONE = 8'h00;
    localparam logic [2:0] BAR_LOW_BITS = 3'h1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLAIM,
        ST_XFER,
        ST_RELEASE
    } ido_state_e;

    typedef struct packed {
        logic [3:0] cmd;
        logic [31:0] addr;
    } ido_req_s;
endpackage

// ===== tb/ido_latch_bank_sva.sv
// Checker for the latch bank's bus answers and output latches.
// Assumes single-data-phase cycles at least two clocks apart.
module ido_latch_bank_sva
    import ido_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic frameN,
    input wire logic irdyN,
    input wire logic idsel,
    input wire logic [3:0] cbeN,
    input wire logic [31:0] adIn,
    input wire logic [31:0] adOut,
    input wire logic adOe,
    input wire logic parOut,
    input wire logic parOe,
    input wire logic devselN,
    input wire logic trdyN,
    input wire logic stopN,
    input wire logic ctlOe,
    input wire logic [15:0] group0Out,
    input wire logic [15:0] group1Out,
    input wire logic [15:0] group2Out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cmdReg;
    logic adr2Reg;
    logic frPrev;
    wire logic done = ctlOe & ~trdyN & ~irdyN;
    wire logic wrLo = done & (cmdReg == CMD_IO_WR) & ~adr2Reg;
    wire logic wrHi = done & (cmdReg == CMD_IO_WR) & adr2Reg;
    wire logic rdOk = adOe & (cmdReg == CMD_IO_RD);
    // Command and window half of the cycle in flight
    always_ff @(posedge mclk) begin
        frPrev <= frameN;
        if (!frameN && frPrev) begin
            cmdReg <= cbeN;
            adr2Reg <= adIn[2];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_claim_order: assert property ($fell(devselN) |=> !trdyN && !stopN)
        else $error("ready late after claim");
    a_ready_framed: assert property (ctlOe && !trdyN |-> !stopN && !devselN)
        else $error("ready without claim");
    a_release_seq: assert property (done |=> trdyN && devselN && stopN && ctlOe ##1 !ctlOe)
        else $error("bad release");
    a_par_follows: assert property ($fell(adOe) |-> parOe ##1 !parOe)
        else $error("parity enable out of step");
    // Parity covers the AD and C/BE levels of the previous clock
    a_par_value: assert property (parOe |-> parOut == (^$past(adOut) ^ ^$past(cbeN)))
        else $error("parity value wrong");
    a_write_g0lo: assert property (wrLo && !cbeN[0] |=> group0Out[7:0] == $past(adIn[7:0]))
        else $error("group0 low not latched");
    a_write_g0hi: assert property (wrLo && !cbeN[1] |=> group0Out[15:8] == $past(adIn[15:8]))
        else $error("group0 high not latched");
    a_write_g1hi: assert property (wrHi && !cbeN[0] |=> group1Out[15:8] == $past(adIn[7:0]))
        else $error("group1 high not latched");
    a_write_g2hi: assert property (wrHi && !cbeN[2] |=> group2Out[15:8] == $past(adIn[23:16]))
        else $error("group2 high not latched");
    a_read_lower: assert property (rdOk && !adr2Reg |-> adOut == {8'h00, group1Out[7:0], group0Out})
        else $error("lower dword read wrong");
    a_read_upper: assert property (rdOk && adr2Reg |-> adOut == {8'h00, group2Out, group1Out[15:8]})
        else $error("upper dword read wrong");
    a_outputs_hold: assert property ($changed({group0Out, group1Out, group2Out}) |-> $past(wrLo || wrHi))
        else $error("outputs moved without write");
    a_reset_clears: assert property (disable iff (1'b0) rst |=> {group0Out, group1Out, group2Out} == 48'h0 && !ctlOe)
        else $error("reset left outputs on");
    c_write: cover property (wrHi);
    c_read: cover property (rdOk);
    c_wait: cover property (ctlOe && !trdyN && irdyN);
endmodule

bind ido_latch_bank ido_latch_bank_sva u_ido_latch_bank_sva (.*);

// ===== tb/ido_host_model.sv
// Bus master model issuing single-phase I/O and config cycles.
// Assumes the design answers within six clocks or not at all.
module ido_host_model
    import ido_pkg::*;
(
    input wire logic mclk,
    input wire logic [31:0] adOut,
    input wire logic adOe,
    input wire logic trdyN,
    input wire logic ctlOe,
    output logic frameN,
    output logic irdyN,
    output logic idsel,
    output logic [3:0] cbeN,
    output logic [31:0] adIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mAd;
    initial begin
        frameN = 1'b1;
        irdyN = 1'b1;
        idsel = 1'b0;
        cbeN = 4'hf;
        mAd = 32'h0;
    end
    assign adIn = adOe ? adOut : mAd;
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] adr, input logic [3:0] be,
        input logic [31:0] wd, input logic cfg, input int wt, output logic [31:0] rd, output logic hit);
        hit = 1'b0;
        rd = 32'h0;
        @(posedge mclk);
        #1 frameN = 1'b0;
        idsel = cfg;
        cbeN = cmd;
        mAd = adr;
        @(posedge mclk);
        #1 idsel = 1'b0;
        cbeN = be;
        // Released AD shows the inverse, never a stale copy
        mAd = cmd[0] ? wd : ~adr;
        repeat (wt) begin
            @(posedge mclk);
            #1;
        end
        frameN = 1'b1;
        irdyN = 1'b0;
        for (int n = 0; n < 6; n++) begin
            if (ctlOe === 1'b1 && trdyN === 1'b0) begin
                hit = 1'b1;
                rd = adIn;
                break;
            end
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        #1 irdyN = 1'b1;
        cbeN = 4'hf;
        mAd = ~mAd;
    endtask
endmodule

// ===== tb/ido_latch_bank_tb.sv
// Testbench for the latch bank: config setup, byte writes, readback, misses.
// Assumes the host model drives all bus inputs.
module ido_latch_bank_tb
    import ido_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] BASE = 32'h0000_0a38;
    localparam logic [15:0] VID = 16'h5a11; // Arbitrary value
    localparam logic [15:0] DID = 16'h7e02; // Arbitrary value
    logic mclk = 1'b0;
    logic rst = 1'b1;
    int errors = 0;
    int checks = 0;
    logic frameN, irdyN, idsel, adOe, trdyN, ctlOe, hit;
    logic [3:0] cbeN;
    logic [31:0] adIn, adOut, rd;
    logic [15:0] g0, g1, g2;
    logic [7:0] v [8];
    always #2.5 mclk = ~mclk;
    ido_latch_bank #(.VENDOR_CODE(VID), .DEVICE_CODE(DID)) u_ido_latch_bank (.mclk(mclk), .rst(rst),
        .frameN(frameN), .irdyN(irdyN), .idsel(idsel), .cbeN(cbeN), .adIn(adIn), .adOut(adOut), .adOe(adOe),
        .parOut(), .parOe(), .devselN(), .trdyN(trdyN), .stopN(), .ctlOe(ctlOe),
        .group0Out(g0), .group1Out(g1), .group2Out(g2));
    ido_host_model u_ido_host_model (.mclk(mclk), .adOut(adOut), .adOe(adOe), .trdyN(trdyN), .ctlOe(ctlOe),
        .frameN(frameN), .irdyN(irdyN), .idsel(idsel), .cbeN(cbeN), .adIn(adIn));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // A wrong claim outcome ends the run at once
    task automatic io(input logic [3:0] cmd, input logic [31:0] adr, input logic [3:0] be, input logic [31:0] wd,
        input logic cfg, input int wt, input logic expHit);
        u_ido_host_model.xfer(cmd, adr, be, wd, cfg, wt, rd, hit);
        chk(48'(hit), 48'(expHit));
        if (hit !== expHit) results();
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        chk({g0, g1, g2}, 48'h0);
        io(CMD_CFG_RD, 32'h0, 4'h0, 32'h0, 1'b1, 0, 1'b1);
        chk(48'(rd), 48'({DID, VID}));
        io(CMD_IO_WR, 32'h0, 4'he, 32'hff, 1'b0, 0, 1'b0);
        io(CMD_CFG_WR, 32'h10, 4'h0, BASE, 1'b1, 0, 1'b1);
        io(CMD_CFG_RD, 32'h10, 4'h0, 32'h0, 1'b1, 0, 1'b1);
        chk(48'(rd), 48'(BASE | 32'h1));
        io(CMD_CFG_WR, 32'h4, 4'he, 32'h1, 1'b1, 0, 1'b1);
        for (int o = 0; o < 8; o++) begin
            v[o] = 8'hc3 ^ (8'h11 * o[7:0]);
            io(CMD_IO_WR, BASE | 32'(o & 4), ~(4'h1 << o[1:0]), 32'(v[o]) << (8 * o[1:0]), 1'b0, o % 2 * 2, 1'b1);
        end
        chk({g0, g1, g2}, {v[1], v[0], v[4], v[2], v[6], v[5]});
        io(CMD_IO_RD, BASE, 4'h0, 32'h0, 1'b0, 1, 1'b1);
        chk(48'(rd), 48'({8'h00, v[2], v[1], v[0]}));
        io(CMD_IO_RD, BASE | 32'h4, 4'h0, 32'h0, 1'b0, 0, 1'b1);
        chk(48'(rd), 48'({8'h00, v[6], v[5], v[4]}));
        io(CMD_IO_WR, BASE + 32'h8, 4'h0, 32'h0, 1'b0, 0, 1'b0);
        io(CMD_IO_WR, BASE - 32'h1, 4'h7, 32'h0, 1'b0, 0, 1'b0);
        chk({g0, g1, g2}, {v[1], v[0], v[4], v[2], v[6], v[5]});
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        chk({g0, g1, g2}, 48'h0);
        results();
    end
endmodule
